// ===== inc/ppm_pkg.sv
// package: register map, field positions and pin indices of the port pin mux block
package ppm_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] PPM_ADDR_DRIVE    = 8'h00;  // port_t_drive_strength
  localparam logic [7:0] PPM_ADDR_PULL_EN  = 8'h01;  // port_t_pull_enable
  localparam logic [7:0] PPM_ADDR_PULL_POL = 8'h02;  // port_t_pull_polarity
  localparam logic [7:0] PPM_ADDR_ROUTE    = 8'h03;  // timer_channel_routing
  localparam logic [7:0] PPM_ADDR_S_DATA   = 8'h04;  // port_s_data

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] PPM_RST_DRIVE     = 8'h00;
  localparam logic [7:0] PPM_RST_PULL_EN   = 8'h00;
  localparam logic [7:0] PPM_RST_PULL_POL  = 8'h00;
  localparam logic [7:0] PPM_RST_ROUTE     = 8'h00;
  localparam logic [7:0] PPM_RST_S_DATA    = 8'h00;
  localparam logic [7:0] PPM_ROUTE_MASK    = 8'h33;  // only bits 5,4,1,0 exist
  localparam logic [7:0] PPM_RD_UNMAPPED   = 8'h00;

  // ----------------------------------------------------------------
  // routing field positions, indexed by timer channel slot
  // slot 0: timer1 ch6, 1: timer1 ch7, 2: timer0 ch6, 3: timer0 ch7
  // ----------------------------------------------------------------
  localparam int PPM_ROUTE_T1C6 = 0;
  localparam int PPM_ROUTE_T1C7 = 1;
  localparam int PPM_ROUTE_T0C6 = 4;
  localparam int PPM_ROUTE_T0C7 = 5;

  // port T pin used by each slot when its routing bit is clear
  localparam int PPM_TPIN_T1C6 = 2;
  localparam int PPM_TPIN_T1C7 = 3;
  localparam int PPM_TPIN_T0C6 = 6;
  localparam int PPM_TPIN_T0C7 = 7;
  // port R pin used by each slot when its routing bit is set
  localparam int PPM_RPIN_T1C6 = 2;
  localparam int PPM_RPIN_T1C7 = 3;
  localparam int PPM_RPIN_T0C6 = 0;
  localparam int PPM_RPIN_T0C7 = 1;

  // ----------------------------------------------------------------
  // port S pin positions
  // ----------------------------------------------------------------
  localparam int PPM_S_SS_SDA  = 7;
  localparam int PPM_S_SCK     = 6;
  localparam int PPM_S_MOSI    = 5;
  localparam int PPM_S_MISO_SCL = 4;
  localparam int PPM_S_CAN_TX  = 3;
  localparam int PPM_S_CAN_RX  = 2;

  // owner of a port S pin, gray coded down the priority chain
  typedef enum logic [2:0] {
    PPM_OWN_GPIO = 3'b000,
    PPM_OWN_PWM  = 3'b001,
    PPM_OWN_I2C  = 3'b011,
    PPM_OWN_SPI  = 3'b010,
    PPM_OWN_CAN  = 3'b110
  } ppm_owner_t;

endpackage

// ===== rtl/ppm_sync.sv
// module: two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module ppm_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // two stages; the first is read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // ppm_sync

// ===== rtl/ppm_top.sv
// module: port T pin configuration, timer routing and port S pin ownership mux
`timescale 1ns/10ps
module ppm_top
  import ppm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // port T pad control
  input  wire logic [7:0] tport_dir_i,
  input  wire logic [7:0] tport_pin_i,
  output logic      [7:0] tport_reduced_o,
  output logic      [7:0] tport_pull_en_o,
  output logic      [7:0] tport_pull_down_o,
  // timer channels, slot order t1c6, t1c7, t0c6, t0c7
  input  wire logic [3:0] timer_oc_en_i,
  input  wire logic [3:0] timer_oc_val_i,
  output logic      [3:0] timer_capture_o,
  output logic      [7:0] tport_tim_en_o,
  output logic      [7:0] tport_tim_val_o,
  input  wire logic [7:0] rport_pin_i,
  output logic      [7:0] rport_tim_en_o,
  output logic      [7:0] rport_tim_val_o,
  // port S pins and direction from the direction register block
  input  wire logic [7:0] second_port_direction_i,
  input  wire logic [7:0] s_pin_i,
  output logic      [7:0] s_pin_o,
  output logic      [7:0] s_pin_oe_o,
  // peripherals on port S; spi index 3..0 is ss, sck, mosi, miso
  input  wire logic       spi_en_i,
  input  wire logic [3:0] spi_out_i,
  input  wire logic [3:0] spi_oe_i,
  output logic      [3:0] spi_in_o,
  input  wire logic       i2c_en_i,
  input  wire logic       i2c_sda_low_i,
  input  wire logic       i2c_scl_low_i,
  output logic            i2c_sda_o,
  output logic            i2c_scl_o,
  input  wire logic [3:0] pulse_en_i,
  input  wire logic [3:0] pulse_val_i,
  input  wire logic       can_en_i,
  input  wire logic       can_tx_i,
  output logic            can_rx_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] drive_strength_bits_q;
  logic [7:0] pull_enable_bits_q;
  logic [7:0] pull_polarity_bits_q;
  logic [7:0] timer_route_bits_q;
  logic [7:0] second_port_data_q;
  logic [7:0] tport_sync;
  logic [7:0] rport_sync;
  logic [7:0] s_sync;
  logic [7:0] s_rd_val;
  logic [7:0] rdata_d;
  logic [3:0] route_sel;
  logic [7:0] s_out_d;
  logic [7:0] s_oe_d;
  logic [7:0] tport_en_d;
  logic [7:0] tport_val_d;
  logic [7:0] rport_en_d;
  logic [7:0] rport_val_d;
  logic [3:0] cap_d;
  ppm_owner_t own [8];

  // ----------------------------------------------------------------
  // pin input synchronisers; pins come from outside the clock domain
  // ----------------------------------------------------------------
  ppm_sync #(.W(24)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .async_i ({tport_pin_i, rport_pin_i, s_pin_i}),
    .sync_o  ({tport_sync, rport_sync, s_sync})
  );

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // writes accepted in every mode, no lock or write-once state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      drive_strength_bits_q <= PPM_RST_DRIVE;
      pull_enable_bits_q    <= PPM_RST_PULL_EN;
      pull_polarity_bits_q  <= PPM_RST_PULL_POL;
      timer_route_bits_q    <= PPM_RST_ROUTE;
      second_port_data_q    <= PPM_RST_S_DATA;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        PPM_ADDR_DRIVE:    drive_strength_bits_q <= wdata_i;
        PPM_ADDR_PULL_EN:  pull_enable_bits_q    <= wdata_i;
        PPM_ADDR_PULL_POL: pull_polarity_bits_q  <= wdata_i;
        PPM_ADDR_ROUTE:    timer_route_bits_q    <= wdata_i & PPM_ROUTE_MASK;
        PPM_ADDR_S_DATA:   second_port_data_q    <= wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path; data stands one cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  // per bit: the latch when the pin is an output, else the pin level
  assign s_rd_val = (second_port_direction_i & second_port_data_q)
                  | (~second_port_direction_i & s_sync);

  always_comb begin
    rdata_d = PPM_RD_UNMAPPED;
    if (rd_i) begin
      case (addr_i)
        PPM_ADDR_DRIVE:    rdata_d = drive_strength_bits_q;
        PPM_ADDR_PULL_EN:  rdata_d = pull_enable_bits_q;
        PPM_ADDR_PULL_POL: rdata_d = pull_polarity_bits_q;
        PPM_ADDR_ROUTE:    rdata_d = timer_route_bits_q;
        PPM_ADDR_S_DATA:   rdata_d = s_rd_val;
        default:           rdata_d = PPM_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // port T pad controls
  // ----------------------------------------------------------------
  // tport_dir_i is the resolved direction, so any driver gets the setting
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tport_reduced_o   <= 8'h00;
      tport_pull_en_o   <= 8'h00;
      tport_pull_down_o <= 8'h00;
    end else if (ce_i) begin
      tport_reduced_o   <= drive_strength_bits_q & tport_dir_i;
      tport_pull_en_o   <= pull_enable_bits_q & ~tport_dir_i;
      tport_pull_down_o <= pull_polarity_bits_q & pull_enable_bits_q
                         & ~tport_dir_i;
    end
  end

  // ----------------------------------------------------------------
  // timer channel routing between port T and port R
  // ----------------------------------------------------------------
  assign route_sel = {timer_route_bits_q[PPM_ROUTE_T0C7],
                      timer_route_bits_q[PPM_ROUTE_T0C6],
                      timer_route_bits_q[PPM_ROUTE_T1C7],
                      timer_route_bits_q[PPM_ROUTE_T1C6]};

  localparam int TPIN [4] = '{PPM_TPIN_T1C6, PPM_TPIN_T1C7, PPM_TPIN_T0C6, PPM_TPIN_T0C7};
  localparam int RPIN [4] = '{PPM_RPIN_T1C6, PPM_RPIN_T1C7, PPM_RPIN_T0C6, PPM_RPIN_T0C7};

  // each slot lands on exactly one pin; the other pin sees no timer
  always_comb begin
    tport_en_d  = 8'h00;
    tport_val_d = 8'h00;
    rport_en_d  = 8'h00;
    rport_val_d = 8'h00;
    cap_d       = 4'h0;
    for (int k = 0; k < 4; k++) begin
      if (route_sel[k]) begin
        rport_en_d[RPIN[k]]  = timer_oc_en_i[k];
        rport_val_d[RPIN[k]] = timer_oc_val_i[k];
        cap_d[k]             = rport_sync[RPIN[k]];
      end else begin
        tport_en_d[TPIN[k]]  = timer_oc_en_i[k];
        tport_val_d[TPIN[k]] = timer_oc_val_i[k];
        cap_d[k]             = tport_sync[TPIN[k]];
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tport_tim_en_o  <= 8'h00;
      tport_tim_val_o <= 8'h00;
      rport_tim_en_o  <= 8'h00;
      rport_tim_val_o <= 8'h00;
      timer_capture_o <= 4'h0;
    end else if (ce_i) begin
      tport_tim_en_o  <= tport_en_d;
      tport_tim_val_o <= tport_val_d;
      rport_tim_en_o  <= rport_en_d;
      rport_tim_val_o <= rport_val_d;
      timer_capture_o <= cap_d;
    end
  end

  // ----------------------------------------------------------------
  // port S ownership by fixed priority
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      own[p] = PPM_OWN_GPIO;
    end
    // pins 7..4 share spi; 7 and 4 also carry i2c
    for (int p = 4; p < 8; p++) begin
      if (spi_en_i) begin
        own[p] = PPM_OWN_SPI;
      end else if (i2c_en_i && (p == PPM_S_SS_SDA || p == PPM_S_MISO_SCL)) begin
        own[p] = PPM_OWN_I2C;
      end else if (pulse_en_i[p-4]) begin
        own[p] = PPM_OWN_PWM;
      end
    end
    if (can_en_i) begin
      own[PPM_S_CAN_TX] = PPM_OWN_CAN;
      own[PPM_S_CAN_RX] = PPM_OWN_CAN;
    end
  end

  // ----------------------------------------------------------------
  // port S drive value and enable per pin
  // ----------------------------------------------------------------
  // i2c is open drain: enable only while pulling low
  generate
    for (genvar g = 0; g < 8; g++) begin : g_spin
      always_comb begin
        case (own[g])
          PPM_OWN_SPI: begin
            s_out_d[g] = (g >= 4) ? spi_out_i[(g >= 4) ? g-4 : 0] : 1'b0;
            s_oe_d[g]  = (g >= 4) ? spi_oe_i[(g >= 4) ? g-4 : 0] : 1'b0;
          end
          PPM_OWN_I2C: begin
            s_out_d[g] = 1'b0;
            s_oe_d[g]  = (g == PPM_S_SS_SDA) ? i2c_sda_low_i : i2c_scl_low_i;
          end
          PPM_OWN_PWM: begin
            s_out_d[g] = (g >= 4) ? pulse_val_i[(g >= 4) ? g-4 : 0] : 1'b0;
            s_oe_d[g]  = 1'b1;                               // forced output
          end
          PPM_OWN_CAN: begin
            s_out_d[g] = can_tx_i;
            s_oe_d[g]  = (g == PPM_S_CAN_TX);                // rx pin stays input
          end
          default: begin
            s_out_d[g] = second_port_data_q[g];
            s_oe_d[g]  = second_port_direction_i[g];
          end
        endcase
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_pin_o    <= 8'h00;
      s_pin_oe_o <= 8'h00;
    end else if (ce_i) begin
      s_pin_o    <= s_out_d;
      s_pin_oe_o <= s_oe_d;
    end
  end

  // ----------------------------------------------------------------
  // peripheral inputs taken from synchronised port S pins
  // ----------------------------------------------------------------
  // peripherals see the pin regardless of ownership; they gate it themselves
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      spi_in_o  <= 4'h0;
      i2c_sda_o <= 1'b1;
      i2c_scl_o <= 1'b1;
      can_rx_o  <= 1'b1;
    end else if (ce_i) begin
      spi_in_o  <= s_sync[7:4];
      i2c_sda_o <= s_sync[PPM_S_SS_SDA];
      i2c_scl_o <= s_sync[PPM_S_MISO_SCL];
      can_rx_o  <= s_sync[PPM_S_CAN_RX];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  drive_input_a: assert property (ce_i && $past(ce_i) && !$past(tport_dir_i[0])
      |-> !tport_reduced_o[0]) else $error("reduced drive on input pin");
  drive_write_a: assert property (ce_i && wr_i && addr_i == PPM_ADDR_DRIVE
      && tport_dir_i == 8'hff ##1 ce_i |-> ##1 (!ce_i || !$past(wr_i,1) ||
      tport_reduced_o == $past(wdata_i, 2) || $past(tport_dir_i) != 8'hff))
      else $error("drive write not seen on pads");
  pull_output_a: assert property (|(tport_pull_en_o & $past(tport_dir_i)) == 1'b0
      || !$past(ce_i)) else $error("pull active on output pin");
  pull_down_a: assert property ((tport_pull_down_o & ~tport_pull_en_o) == 8'h00)
      else $error("pull-down without pull enable");
  route_mask_a: assert property ((timer_route_bits_q & ~PPM_ROUTE_MASK) == 8'h00)
      else $error("undefined routing bit stored");
  route_excl_a: assert property (!(tport_tim_en_o[7] && rport_tim_en_o[1]))
      else $error("timer0 ch7 on two pins");
  route_t0c6_a: assert property (ce_i && $past(ce_i) && $past(timer_route_bits_q[4])
      && $past(timer_oc_en_i[2]) |-> rport_tim_en_o[0] && !tport_tim_en_o[6])
      else $error("timer0 ch6 misrouted");
  spi_owns_a: assert property (ce_i && spi_en_i && spi_oe_i[3] ##1 ce_i
      |-> s_pin_oe_o[7]) else $error("spi lost pin7");
  can_tx_a: assert property (ce_i && can_en_i ##1 ce_i |-> s_pin_oe_o[2] == 1'b0
      && s_pin_o[3] == $past(can_tx_i)) else $error("can pins wrong");
  gpio_out_a: assert property (ce_i && !spi_en_i && !i2c_en_i && pulse_en_i == 4'h0
      && !can_en_i ##1 ce_i |-> s_pin_o == $past(second_port_data_q)
      && s_pin_oe_o == $past(second_port_direction_i))
      else $error("gpio drive wrong");
  read_data_a: assert property (ce_i && rd_i && addr_i == PPM_ADDR_S_DATA ##1 ce_i
      |-> rdata_o == $past(s_rd_val)) else $error("port S read wrong");
  i2c_open_a: assert property (ce_i && !spi_en_i && i2c_en_i ##1 ce_i
      |-> !s_pin_o[4] && s_pin_oe_o[4] == $past(i2c_scl_low_i))
      else $error("i2c scl not open drain");

  spi_mode_c: cover property (ce_i && spi_en_i ##1 s_pin_oe_o[6]);
  i2c_mode_c: cover property (ce_i && i2c_en_i && !spi_en_i ##1 s_pin_oe_o[7]);
  route_r_c:  cover property (rport_tim_en_o[1] ##1 tport_tim_en_o[7]);
  read_s_c:   cover property (rd_i && addr_i == PPM_ADDR_S_DATA ##1 rdata_o != 8'h00);

endmodule // ppm_top

// ===== tb/ppm_pin_model.sv
// partner model: board side levels of the port T and port S pins
`timescale 1ns/10ps
module ppm_pin_model (
  input  wire logic [7:0] dev_s_i,
  input  wire logic [7:0] dev_s_oe_i,
  input  wire logic [7:0] s_ext_i,
  input  wire logic [7:0] t_drv_en_i,
  input  wire logic [7:0] t_drv_val_i,
  input  wire logic [7:0] t_pull_en_i,
  input  wire logic [7:0] t_pull_dn_i,
  input  wire logic [7:0] t_ext_i,
  output logic      [7:0] s_level_o,
  output logic      [7:0] t_level_o
);
  // port S: device drive wins; a released pin follows the board driver
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      s_level_o[i] = dev_s_oe_i[i] ? dev_s_i[i] : s_ext_i[i];
    end
  end

  // port T: timer drive first, then the weak pull, the board only when nothing else acts
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (t_drv_en_i[i]) begin
        t_level_o[i] = t_drv_val_i[i];
      end else if (t_pull_en_i[i]) begin
        t_level_o[i] = ~t_pull_dn_i[i];
      end else begin
        t_level_o[i] = t_ext_i[i];
      end
    end
  end
endmodule // ppm_pin_model

// ===== tb/test_port_pin_config_and_mux.sv
// testbench: register access, port T pads, timer routing and port S pin ownership
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_port_pin_config_and_mux
  import ppm_pkg::*;
;
  typedef struct packed {
    logic [7:0] a, d, rd;
    logic [3:0] en;
    logic [7:0] o, oe;
  } ppm_row_t;

  logic       clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, spi_en_i = 1'b0;
  logic       i2c_en_i = 1'b0, can_en_i = 1'b0, i2c_sda_low_i = 1'b1, i2c_scl_low_i = 1'b0;
  logic       can_tx_i = 1'b0, ce_i = 1'b1;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, tport_dir_i = 8'h00, rport_pin_i = 8'h00;
  logic [7:0] second_port_direction_i = 8'hff, s_ext = 8'ha0, t_ext = 8'h04;
  logic [3:0] timer_oc_en_i = 4'h0, timer_oc_val_i = 4'ha, spi_out_i = 4'h9, spi_oe_i = 4'h6;
  logic [3:0] pulse_en_i = 4'h0, pulse_val_i = 4'h5;
  logic       i2c_sda_o, i2c_scl_o, can_rx_o;
  logic [7:0] rdata_o, tport_pin_i, tport_reduced_o, tport_pull_en_o, tport_pull_down_o;
  logic [7:0] tport_tim_en_o, tport_tim_val_o, rport_tim_en_o, rport_tim_val_o;
  logic [7:0] s_pin_i, s_pin_o, s_pin_oe_o;
  logic [3:0] timer_capture_o, spi_in_o;
  int         bad_count = 0, n_tests = 0, cycles = 0;
  ppm_row_t   rows [6];

  // the clock enable is driven so that one scenario can check the freeze
  ppm_top dut_u (
    .clk_i, .reset_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .tport_dir_i,
    .tport_pin_i, .tport_reduced_o, .tport_pull_en_o, .tport_pull_down_o, .timer_oc_en_i,
    .timer_oc_val_i, .timer_capture_o, .tport_tim_en_o, .tport_tim_val_o, .rport_pin_i,
    .rport_tim_en_o, .rport_tim_val_o, .second_port_direction_i, .s_pin_i, .s_pin_o,
    .s_pin_oe_o, .spi_en_i, .spi_out_i, .spi_oe_i, .spi_in_o, .i2c_en_i, .i2c_sda_low_i,
    .i2c_scl_low_i, .i2c_sda_o, .i2c_scl_o, .pulse_en_i, .pulse_val_i, .can_en_i, .can_tx_i,
    .can_rx_o
  );
  ppm_pin_model pins_u (
    .dev_s_i(s_pin_o), .dev_s_oe_i(s_pin_oe_o), .s_ext_i(s_ext), .t_drv_en_i(tport_tim_en_o),
    .t_drv_val_i(tport_tim_val_o), .t_pull_en_i(tport_pull_en_o),
    .t_pull_dn_i(tport_pull_down_o), .t_ext_i(t_ext), .s_level_o(s_pin_i),
    .t_level_o(tport_pin_i)
  );

  // ----------------------------------------------------------------
  // clock, hang guard and bus tasks
  // ----------------------------------------------------------------
  always #50 clk_i = ~clk_i;

  // the whole run needs about 135 cycles; over twenty times that means a hang
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // pins pass a two stage synchroniser plus an output flop, so five cycles is ample
  task automatic settle();
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    // enable nibble: spi, i2c, pulse, can
    rows = '{'{PPM_ADDR_S_DATA, 8'h3c, 8'h3c, 4'h0, 8'h3c, 8'hff},
             '{PPM_ADDR_DRIVE, 8'ha5, 8'ha5, 4'h2, 8'h5c, 8'hff},
             '{PPM_ADDR_PULL_EN, 8'h5a, 8'h5a, 4'h6, 8'h4c, 8'hef},
             '{PPM_ADDR_PULL_POL, 8'hc3, 8'hc3, 4'he, 8'h9c, 8'h6f},
             '{PPM_ADDR_ROUTE, 8'hff, 8'h33, 4'hf, 8'h90, 8'h6b},
             '{8'h07, 8'hff, 8'h00, 4'h1, 8'h30, 8'hfb}};
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].d);
      reg_rd(rows[i].a, v);
      `CHK("readback", rows[i].rd, v)
      @(posedge clk_i);
      spi_en_i <= rows[i].en[3];
      i2c_en_i <= rows[i].en[2];
      pulse_en_i <= {4{rows[i].en[1]}};
      can_en_i <= rows[i].en[0];
      settle();
      `CHK("s_pin_o", rows[i].o, s_pin_o)
      `CHK("s_pin_oe_o", rows[i].oe, s_pin_oe_o)
    end
    // port T pads with half the pins as outputs and timers driving
    @(posedge clk_i);
    tport_dir_i <= 8'h0f;
    timer_oc_en_i <= 4'hf;
    reg_wr(PPM_ADDR_DRIVE, 8'hff);
    reg_wr(PPM_ADDR_PULL_EN, 8'hff);
    reg_wr(PPM_ADDR_PULL_POL, 8'h55);
    reg_wr(PPM_ADDR_ROUTE, 8'h00);
    settle();
    `CHK("reduced", 8'h0f, tport_reduced_o)
    `CHK("pull_en", 8'hf0, tport_pull_en_o)
    `CHK("pull_down", 8'h50, tport_pull_down_o)
    `CHK("t_tim_en", 8'hcc, tport_tim_en_o)
    `CHK("t_tim_val", 8'h88, tport_tim_val_o)
    `CHK("r_tim_en", 8'h00, rport_tim_en_o)
    `CHK("capture_t", 4'ha, timer_capture_o)
    // every channel moved over to port R
    @(posedge clk_i);
    rport_pin_i <= 8'h06;
    reg_wr(PPM_ADDR_ROUTE, 8'h33);
    settle();
    `CHK("r_tim_en", 8'h0f, rport_tim_en_o)
    `CHK("r_tim_val", 8'h0a, rport_tim_val_o)
    `CHK("t_tim_en", 8'h00, tport_tim_en_o)
    `CHK("capture_r", 4'h9, timer_capture_o)
    // port S read source follows direction; released pins come from the board
    @(posedge clk_i);
    {spi_en_i, i2c_en_i, can_en_i} <= 3'b000;
    pulse_en_i <= 4'h0;
    second_port_direction_i <= 8'h0f;
    settle();
    reg_rd(PPM_ADDR_S_DATA, v);
    `CHK("s_read", 8'hac, v)
    `CHK("spi_in", 4'ha, spi_in_o)
    `CHK("sda_in", 1'b1, i2c_sda_o)
    `CHK("scl_in", 1'b0, i2c_scl_o)
    `CHK("can_rx", 1'b1, can_rx_o)
    @(posedge clk_i);
    can_en_i <= 1'b1;
    settle();
    `CHK("can_rx", 1'b0, can_rx_o)
    `CHK("s_oe_can", 8'h0b, s_pin_oe_o)
    // clock enable low holds every flop, so this write is lost
    @(posedge clk_i);
    ce_i <= 1'b0;
    tport_dir_i <= 8'hff;
    reg_wr(PPM_ADDR_DRIVE, 8'h3c);
    settle();
    `CHK("frozen", 8'h0f, tport_reduced_o)
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle();
    `CHK("drive_kept", 8'hff, tport_reduced_o)
    // every pin an output: the pads follow a fresh drive write
    reg_wr(PPM_ADDR_DRIVE, 8'h3c);
    settle();
    `CHK("reduced_all", 8'h3c, tport_reduced_o)
    // second reset in mid-run clears every configuration register; the i2c inputs reset high
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK("oe_rst", 8'h00, s_pin_oe_o)
    `CHK("sda_rst", 1'b1, i2c_sda_o)
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      reg_rd(8'(a), v);
      // port S upper pins are inputs, so their read shows the board level
      `CHK("reset_val", ((a == 4) ? 8'ha0 : 8'h00), v)
    end
    complete_run();
  end
endmodule // test_port_pin_config_and_mux
